// ===== design/msr_params.svh
// Register offsets, field positions, reset values and command codes of the status readback
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH

// ****************************************************************
// Register word offsets
// ****************************************************************
`define MSR_OFS_MAIN 4'h0
`define MSR_OFS_CONFIG 4'h1
`define MSR_OFS_ERRFIN 4'h2
`define MSR_OFS_INPUT 4'h3
`define MSR_OFS_COMPARE 4'h4
`define MSR_OFS_GIO 4'h5
`define MSR_OFS_RD_LOW 4'h6
`define MSR_OFS_RD_HIGH 4'h7
`define MSR_OFS_GIO_DIR 4'h8
`define MSR_OFS_GIO_OUT 4'h9
`define MSR_OFS_SPOS_LOW 4'ha
`define MSR_OFS_SPOS_HIGH 4'hb
`define MSR_OFS_SNEG_LOW 4'hc
`define MSR_OFS_SNEG_HIGH 4'hd

// ****************************************************************
// Field positions
// ****************************************************************
`define MSR_MAIN_DRIVE 0
`define MSR_MAIN_ERROR 1
`define MSR_EF_SOFT_POS 0
`define MSR_EF_SOFT_NEG 1
`define MSR_EF_HARD_POS 2
`define MSR_EF_HARD_NEG 3
`define MSR_EF_ALARM 4
`define MSR_EF_EMG 5
`define MSR_EF_HOME 6
`define MSR_EF_SYNC 8
`define MSR_EF_STOP0 9
`define MSR_EF_LIM_POS 12
`define MSR_EF_LIM_NEG 13
`define MSR_EF_ALARM_FIN 14
`define MSR_EF_EMG_FIN 15
`define MSR_IN_STEP_LSB 9

// ****************************************************************
// Reset values
// ****************************************************************
`define MSR_RST_WORD 16'h0000
`define MSR_RST_LONG 32'h00000000
`define MSR_RST_BYTE 8'h00

// ****************************************************************
// Command codes and home search step
// ****************************************************************
`define MSR_CMD_CLEAR 8'h79
`define MSR_CMD_READ_FIRST 8'h30
`define MSR_CMD_READ_LAST 8'h38
`define MSR_CMD_DRIVE_POS 8'h50
`define MSR_CMD_DRIVE_NEG 8'h51
`define MSR_CMD_STOP 8'h56
`define MSR_HOME_STEP3 6'h03

`endif

// ===== design/msr_pkg.sv
// Types shared by the status readback block
package msr_pkg;

  // Pins from the axis sensors and servo driver
  typedef struct packed {
    logic emg_n;
    logic neg_limit;
    logic pos_limit;
    logic alarm;
    logic settled;
    logic enc_b;
    logic enc_a;
    logic [2:0] stop;
  } msr_pins_t;

  // Internal values offered to the data-read command
  typedef struct packed {
    logic [31:0] timer;
    logic [3:0][31:0] mpreg;
    logic [31:0] accel;
    logic [31:0] speed;
    logic [31:0] real_pos;
    logic [31:0] logical_pos;
  } msr_sources_t;

  // Software configuration word
  typedef struct packed {
    logic [4:0] spare;
    logic limit_input_swap;
    logic stop_active_high;
    logic [2:0] stop_enable;
    logic alarm_active_high;
    logic limit_active_high;
    logic alarm_enable;
    logic hard_limit_enable;
    logic soft_limit_enable;
    logic unused0;
  } msr_config_t;

  // Drive state
  typedef enum logic [1:0] {
    MSR_IDLE = 2'b01,
    MSR_DRIVING = 2'b10
  } msr_drive_t;

endpackage : msr_pkg

// ===== design/msr_readback.sv
// Status readback block of a single-axis pulse motion controller
//
// Function
// - Error flags set on drive errors, summary
// - Flags sticky; cleared by command or start
// - Positive soft limit reached sets D0, stops
// - Below negative soft limit sets D1, stops
// - Hard limits set D2/D3 and stop
// - Enabled servo alarm sets D4, stops
// - Emergency input low sets D5, stops
// - Index active entering step three sets D6
// - Limit refuses same-direction drive, errors again
// - Idle sets error flags only on a refused start
// - Opposite-side limit ignored in reverse drive
// - Upper byte records drive-ending cause
// - Pulse end, stop command, soft limit, index: none
// - Input register shows raw pin levels
// - Encoder and limit bits ignore swaps
// - Home search step code in D14~9
// - Compare flags per register, upper byte zero
// - Lower I/O byte shows general pins
// - Upper I/O byte: inputs in narrow mode
// - Data-read loads 32-bit value split
// - Drive bit high while pulses emitted
`timescale 1ns/1ps
`include "msr_params.svh"

module msr_readback (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire msr_pkg::msr_pins_t pins_in,
  input wire logic [7:0] gio_in,
  output logic [7:0] gio_out,
  output logic [7:0] gio_oe_out,
  input wire logic [7:0] upper_inputs_in,
  input wire logic bus_width_select_in,
  input wire logic [31:0] compare_position_in,
  input wire logic [31:0] compare_object_in,
  input wire msr_pkg::msr_sources_t sources_in,
  input wire logic [5:0] home_step_code_in,
  input wire logic pulses_done_in,
  input wire logic sync_stop_in,
  output logic drive_active_out,
  output logic drive_negative_out
);
  import msr_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Signed greater-or-equal, used by soft limits and compare flags
  function automatic logic signed_ge(input logic [31:0] a, input logic [31:0] b);
    signed_ge = $signed(a) >= $signed(b);
  endfunction : signed_ge

  // Active level of an input with selectable polarity
  function automatic logic is_active(input logic level, input logic active_high);
    is_active = active_high ? level : ~level;
  endfunction : is_active

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  msr_pins_t pins_meta_reg;
  msr_pins_t pins_reg;
  logic [7:0] gio_meta_reg;
  logic [7:0] gio_sync_reg;
  logic [7:0] upper_meta_reg;
  logic [7:0] upper_sync_reg;
  logic width_meta_reg;
  logic width_sync_reg;

  // Two stages for every pin; only the second stage is read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_meta_reg <= '0;
      pins_reg <= '0;
      gio_meta_reg <= `MSR_RST_BYTE;
      gio_sync_reg <= `MSR_RST_BYTE;
      upper_meta_reg <= `MSR_RST_BYTE;
      upper_sync_reg <= `MSR_RST_BYTE;
      width_meta_reg <= 1'b0;
      width_sync_reg <= 1'b0;
    end else if (ce_in) begin
      pins_meta_reg <= pins_in;
      pins_reg <= pins_meta_reg;
      gio_meta_reg <= gio_in;
      gio_sync_reg <= gio_meta_reg;
      upper_meta_reg <= upper_inputs_in;
      upper_sync_reg <= upper_meta_reg;
      width_meta_reg <= bus_width_select_in;
      width_sync_reg <= width_meta_reg;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  msr_config_t config_reg;
  logic [7:0] gio_dir_reg;
  logic [7:0] gio_level_reg;
  logic [31:0] soft_pos_reg;
  logic [31:0] soft_neg_reg;
  logic cmd_write;
  logic [7:0] cmd_code;

  assign cmd_write = wr_in && (addr_in == `MSR_OFS_MAIN);
  assign cmd_code = wdata_in[7:0];

  // Configuration and limit words; writes only, reads never alter them
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      config_reg <= '0;
      gio_dir_reg <= `MSR_RST_BYTE;
      gio_level_reg <= `MSR_RST_BYTE;
      soft_pos_reg <= `MSR_RST_LONG;
      soft_neg_reg <= `MSR_RST_LONG;
    end else if (ce_in && wr_in) begin
      case (addr_in)
        `MSR_OFS_CONFIG: config_reg <= msr_config_t'(wdata_in);
        `MSR_OFS_GIO_DIR: gio_dir_reg <= wdata_in[7:0];
        `MSR_OFS_GIO_OUT: gio_level_reg <= wdata_in[7:0];
        `MSR_OFS_SPOS_LOW: soft_pos_reg[15:0] <= wdata_in;
        `MSR_OFS_SPOS_HIGH: soft_pos_reg[31:16] <= wdata_in;
        `MSR_OFS_SNEG_LOW: soft_neg_reg[15:0] <= wdata_in;
        `MSR_OFS_SNEG_HIGH: soft_neg_reg[31:16] <= wdata_in;
        default: ;
      endcase
    end
  end

  // General pins driven from flip-flops
  assign gio_out = gio_level_reg;
  assign gio_oe_out = gio_dir_reg;

  // ****************************************************************
  // Error and stop causes
  // ****************************************************************
  msr_drive_t drive_reg;
  logic dir_neg_reg;
  logic [5:0] step_prev_reg;
  logic running;
  logic pos_lim_act;
  logic neg_lim_act;
  logic soft_pos_cond;
  logic soft_neg_cond;
  logic hard_pos_cond;
  logic hard_neg_cond;
  logic alarm_cond;
  logic emg_cond;
  logic [2:0] ext_stop;
  logic home_cond;
  logic start_pos_cmd;
  logic start_neg_cmd;
  logic refuse_pos;
  logic refuse_neg;
  logic start_ok;
  logic stop_now;

  assign running = (drive_reg == MSR_DRIVING);

  // Swap steers the stop logic and the limit error flags, never the input register bits
  assign pos_lim_act = is_active(config_reg.limit_input_swap ? pins_reg.neg_limit :
                                 pins_reg.pos_limit, config_reg.limit_active_high);
  assign neg_lim_act = is_active(config_reg.limit_input_swap ? pins_reg.pos_limit :
                                 pins_reg.neg_limit, config_reg.limit_active_high);

  // Enable-qualified limit conditions; drive direction is applied later
  assign soft_pos_cond = config_reg.soft_limit_enable &&
                         signed_ge(compare_position_in, soft_pos_reg);
  assign soft_neg_cond = config_reg.soft_limit_enable &&
                         !signed_ge(compare_position_in, soft_neg_reg);
  assign hard_pos_cond = config_reg.hard_limit_enable && pos_lim_act;
  assign hard_neg_cond = config_reg.hard_limit_enable && neg_lim_act;
  assign alarm_cond = config_reg.alarm_enable &&
                      is_active(pins_reg.alarm, config_reg.alarm_active_high);
  assign emg_cond = !pins_reg.emg_n;

  // Index input is stop input 2; checked only on entry into step three
  assign home_cond = (home_step_code_in == `MSR_HOME_STEP3) &&
                     (step_prev_reg != `MSR_HOME_STEP3) &&
                     is_active(pins_reg.stop[2], config_reg.stop_active_high);

  // Enabled external stop inputs
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ext_stop[i] = config_reg.stop_enable[i] &&
                    is_active(pins_reg.stop[i], config_reg.stop_active_high);
    end
  end

  // Start requests and refusal while a limit on that side stands
  assign start_pos_cmd = cmd_write && (cmd_code == `MSR_CMD_DRIVE_POS) && !running;
  assign start_neg_cmd = cmd_write && (cmd_code == `MSR_CMD_DRIVE_NEG) && !running;
  assign refuse_pos = soft_pos_cond || hard_pos_cond;
  assign refuse_neg = soft_neg_cond || hard_neg_cond;
  assign start_ok = (start_pos_cmd && !refuse_pos) || (start_neg_cmd && !refuse_neg);

  // Any cause ends the drive in the same cycle; no deceleration here
  assign stop_now = running && (
    (!dir_neg_reg && (soft_pos_cond || hard_pos_cond)) ||
    (dir_neg_reg && (soft_neg_cond || hard_neg_cond)) ||
    alarm_cond || emg_cond || home_cond || (|ext_stop) || sync_stop_in ||
    pulses_done_in || (cmd_write && (cmd_code == `MSR_CMD_STOP)));

  // ****************************************************************
  // Drive state
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_reg <= MSR_IDLE;
      dir_neg_reg <= 1'b0;
    end else if (ce_in) begin
      case (drive_reg)
        MSR_IDLE: begin
          if (start_ok) begin
            drive_reg <= MSR_DRIVING;
            dir_neg_reg <= start_neg_cmd;
          end
        end
        MSR_DRIVING: begin
          if (stop_now) begin
            drive_reg <= MSR_IDLE;
          end
        end
        default: drive_reg <= MSR_IDLE;
      endcase
    end
  end

  // Step history for the entry detection of step three
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      step_prev_reg <= 6'h00;
    end else if (ce_in) begin
      step_prev_reg <= home_step_code_in;
    end
  end

  assign drive_active_out = running;
  assign drive_negative_out = dir_neg_reg;

  // ****************************************************************
  // Error and finish flags
  // ****************************************************************
  logic [15:0] errfin_reg;
  logic [15:0] errfin_set;
  logic errfin_clear;

  // Events only while driving, except a refused start
  always_comb begin
    errfin_set = 16'h0000;
    if (running) begin
      errfin_set[`MSR_EF_SOFT_POS] = !dir_neg_reg && soft_pos_cond;
      errfin_set[`MSR_EF_SOFT_NEG] = dir_neg_reg && soft_neg_cond;
      errfin_set[`MSR_EF_HARD_POS] = !dir_neg_reg && hard_pos_cond;
      errfin_set[`MSR_EF_HARD_NEG] = dir_neg_reg && hard_neg_cond;
      errfin_set[`MSR_EF_ALARM] = alarm_cond;
      errfin_set[`MSR_EF_EMG] = emg_cond;
      errfin_set[`MSR_EF_HOME] = home_cond;
      // Finish causes; soft limit, pulse end and stop command leave these clear
      errfin_set[`MSR_EF_SYNC] = sync_stop_in;
      errfin_set[`MSR_EF_STOP0 +: 3] = ext_stop;
      errfin_set[`MSR_EF_LIM_POS] = !dir_neg_reg && hard_pos_cond;
      errfin_set[`MSR_EF_LIM_NEG] = dir_neg_reg && hard_neg_cond;
      errfin_set[`MSR_EF_ALARM_FIN] = alarm_cond;
      errfin_set[`MSR_EF_EMG_FIN] = emg_cond;
    end
    if (start_pos_cmd && refuse_pos) begin
      errfin_set[`MSR_EF_SOFT_POS] = soft_pos_cond;
      errfin_set[`MSR_EF_HARD_POS] = hard_pos_cond;
    end
    if (start_neg_cmd && refuse_neg) begin
      errfin_set[`MSR_EF_SOFT_NEG] = soft_neg_cond;
      errfin_set[`MSR_EF_HARD_NEG] = hard_neg_cond;
    end
  end

  assign errfin_clear = (cmd_write && (cmd_code == `MSR_CMD_CLEAR)) || start_ok;

  // Sticky flags; a set in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      errfin_reg <= `MSR_RST_WORD;
    end else if (ce_in) begin
      errfin_reg <= (errfin_clear ? 16'h0000 : errfin_reg) | errfin_set;
    end
  end

  // ****************************************************************
  // Status words
  // ****************************************************************
  logic [15:0] main_word;
  logic [15:0] input_word;
  logic [15:0] compare_reg;
  logic [15:0] gio_word;

  // Summary error bit follows the low seven flags
  always_comb begin
    main_word = 16'h0000;
    main_word[`MSR_MAIN_DRIVE] = running;
    main_word[`MSR_MAIN_ERROR] = |errfin_reg[6:0];
  end

  // Raw pin levels at fixed positions plus step code
  assign input_word = {pins_reg.emg_n, home_step_code_in, pins_reg.neg_limit,
                       pins_reg.pos_limit, pins_reg.alarm, pins_reg.settled,
                       pins_reg.enc_b, pins_reg.enc_a, pins_reg.stop};

  // Comparison flags; the compared quantity is chosen elsewhere by mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      compare_reg <= `MSR_RST_WORD;
    end else if (ce_in) begin
      compare_reg <= 16'h0000;
      for (int n = 0; n < 4; n++) begin
        compare_reg[2 * n] <= signed_ge(compare_object_in, sources_in.mpreg[n]);
        compare_reg[2 * n + 1] <= compare_object_in == sources_in.mpreg[n];
      end
    end
  end

  // Outputs show driven level, inputs the sampled level
  always_comb begin
    gio_word[7:0] = (gio_dir_reg & gio_level_reg) | (~gio_dir_reg & gio_sync_reg);
    gio_word[15:8] = width_sync_reg ? 8'h00 : upper_sync_reg;
  end

  // ****************************************************************
  // Data-read value
  // ****************************************************************
  logic [31:0] read_data_reg;

  // Loaded only by a data-read command; unknown codes leave it alone
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      read_data_reg <= `MSR_RST_LONG;
    end else if (ce_in && cmd_write) begin
      case (cmd_code)
        8'h30: read_data_reg <= sources_in.logical_pos;
        8'h31: read_data_reg <= sources_in.real_pos;
        8'h32: read_data_reg <= sources_in.speed;
        8'h33: read_data_reg <= sources_in.accel;
        8'h34: read_data_reg <= sources_in.mpreg[0];
        8'h35: read_data_reg <= sources_in.mpreg[1];
        8'h36: read_data_reg <= sources_in.mpreg[2];
        8'h37: read_data_reg <= sources_in.mpreg[3];
        `MSR_CMD_READ_LAST: read_data_reg <= sources_in.timer;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************

  // Data stands only in the cycle after the strobe; reads change nothing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= `MSR_RST_WORD;
    end else if (ce_in) begin
      rdata_out <= 16'h0000;
      if (rd_in) begin
        case (addr_in)
          `MSR_OFS_MAIN: rdata_out <= main_word;
          `MSR_OFS_CONFIG: rdata_out <= 16'(config_reg);
          `MSR_OFS_ERRFIN: rdata_out <= errfin_reg;
          `MSR_OFS_INPUT: rdata_out <= input_word;
          `MSR_OFS_COMPARE: rdata_out <= compare_reg;
          `MSR_OFS_GIO: rdata_out <= gio_word;
          `MSR_OFS_RD_LOW: rdata_out <= read_data_reg[15:0];
          `MSR_OFS_RD_HIGH: rdata_out <= read_data_reg[31:16];
          `MSR_OFS_GIO_DIR: rdata_out <= {8'h00, gio_dir_reg};
          `MSR_OFS_GIO_OUT: rdata_out <= {8'h00, gio_level_reg};
          `MSR_OFS_SPOS_LOW: rdata_out <= soft_pos_reg[15:0];
          `MSR_OFS_SPOS_HIGH: rdata_out <= soft_pos_reg[31:16];
          `MSR_OFS_SNEG_LOW: rdata_out <= soft_neg_reg[15:0];
          `MSR_OFS_SNEG_HIGH: rdata_out <= soft_neg_reg[31:16];
          default: rdata_out <= 16'h0000;
        endcase
      end
    end
  end

endmodule : msr_readback

// ===== testbench/msr_readback_sva.sv
// Port assertions for the status readback block
`timescale 1ns/1ps
`include "msr_params.svh"

module msr_readback_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire msr_pkg::msr_pins_t pins_in,
  input wire logic [7:0] gio_out,
  input wire logic [7:0] gio_oe_out,
  input wire logic bus_width_select_in,
  input wire logic pulses_done_in,
  input wire logic sync_stop_in,
  input wire logic drive_active_out
);
  import msr_pkg::*;
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(a);
    ce_in && rd_in && addr_in == a;
  endsequence
  sequence s_cmd(c);
    ce_in && wr_in && addr_in == `MSR_OFS_MAIN && wdata_in[7:0] == c;
  endsequence
  // Pin must stay low long enough to pass the synchroniser
  sequence s_emg_low;
    drive_active_out && ce_in && !pins_in.emg_n ##1 !pins_in.emg_n [*3];
  endsequence
  property p_rdata_idle;
    ce_in && !rd_in |=> rdata_out == 16'h0000;
  endproperty
  property p_cmp_upper;
    s_rd(`MSR_OFS_COMPARE) |=> rdata_out[15:8] == 8'h00;
  endproperty
  property p_gio_wide;
    bus_width_select_in [*3] ##0 s_rd(`MSR_OFS_GIO) |=> rdata_out[15:8] == 8'h00;
  endproperty
  property p_stop_cmd;
    drive_active_out ##0 s_cmd(`MSR_CMD_STOP) |=> !drive_active_out;
  endproperty
  property p_emg;
    s_emg_low |-> ##[0:2] !drive_active_out;
  endproperty
  property p_read_quiet;
    rd_in && !drive_active_out |=> !drive_active_out && $stable(gio_out) && $stable(gio_oe_out);
  endproperty
  property p_gio_hold;
    !(wr_in && addr_in == `MSR_OFS_GIO_OUT) |=> $stable(gio_out);
  endproperty
  property p_done;
    drive_active_out && ce_in && pulses_done_in |=> !drive_active_out;
  endproperty
  property p_sync;
    drive_active_out && ce_in && sync_stop_in |=> !drive_active_out;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
  a_cmp_upper: assert property (p_cmp_upper) else $error("compare upper");
  a_gio_wide: assert property (p_gio_wide) else $error("wide bus upper");
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop cmd");
  a_emg: assert property (p_emg) else $error("emergency stop");
  a_read_quiet: assert property (p_read_quiet) else $error("read effect");
  a_gio_hold: assert property (p_gio_hold) else $error("gio changed");
  a_done: assert property (p_done) else $error("pulses done");
  a_sync: assert property (p_sync) else $error("sync stop");
endmodule : msr_readback_sva

bind msr_readback msr_readback_sva u_sva (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pins_in(pins_in), .gio_out(gio_out), .gio_oe_out(gio_oe_out),
  .bus_width_select_in(bus_width_select_in), .pulses_done_in(pulses_done_in),
  .sync_stop_in(sync_stop_in), .drive_active_out(drive_active_out));

// ===== testbench/msr_pin_model.sv
// Board model of the general io pins
`timescale 1ns/1ps

module msr_pin_model (
  input wire logic [7:0] gio_out_in,
  input wire logic [7:0] gio_oe_in,
  input wire logic [7:0] ext_level_in,
  output logic [7:0] gio_level_out
);
  // Device wins where it drives; board level elsewhere
  assign gio_level_out = (gio_oe_in & gio_out_in) | (~gio_oe_in & ext_level_in);
endmodule : msr_pin_model

// ===== testbench/testbench.sv
// Self-checking testbench of the status readback block
`timescale 1ns/1ps

module testbench;
  import msr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_q1 = 1'b0;
  logic [15:0] rdata_out;
  msr_pins_t pins_in = 10'h200;
  logic [7:0] gio_in, gio_out, gio_oe_out;
  logic [7:0] gio_ext = 8'h00;
  logic [7:0] upper_in = 8'h00;
  logic bus_wide = 1'b1;
  logic [31:0] cmp_pos = 32'h0;
  logic [31:0] cmp_obj = 32'h0;
  msr_sources_t src = '0;
  logic [5:0] step = 6'h00;
  logic done_p = 1'b0;
  logic sync_p = 1'b0;
  logic drv, drv_neg;
  integer seed = 32'h6acfe58d;
  integer num_errors = 0;
  integer n_tests = 0;
  logic [15:0] exp_q[$];
  logic [15:0] mask_q[$];

  msr_readback u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pins_in(pins_in), .gio_in(gio_in), .gio_out(gio_out), .gio_oe_out(gio_oe_out),
    .upper_inputs_in(upper_in), .bus_width_select_in(bus_wide),
    .compare_position_in(cmp_pos), .compare_object_in(cmp_obj), .sources_in(src),
    .home_step_code_in(step), .pulses_done_in(done_p), .sync_stop_in(sync_p),
    .drive_active_out(drv), .drive_negative_out(drv_neg));
  msr_pin_model u_pins (.gio_out_in(gio_out), .gio_oe_in(gio_oe_out),
    .ext_level_in(gio_ext), .gio_level_out(gio_in));

  // ****************************************************************
  // Clock, bus tasks and result watcher
  // ****************************************************************
  always #20 clk_in = ~clk_in;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input logic [15:0] m);
    n_tests++;
    if ((seen & m) !== (exp & m)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    rd_q1 <= rd_in;
    if (rd_q1) begin
      check(rdata_out, exp_q.pop_front(), mask_q.pop_front());
    end
  end
  // One cause switched on or off; pulses last one cycle
  task automatic set_cause(input int k, input logic on);
    @(posedge clk_in);
    case (k)
      0: pins_in.emg_n <= !on;
      1: pins_in.alarm <= on;
      2: pins_in.pos_limit <= on;
      3: pins_in.neg_limit <= on;
      4: cmp_pos <= on ? 32'h00001000 : 32'h0;
      5: cmp_pos <= on ? 32'hffffefff : 32'h0;
      6: done_p <= on;
      7: if (on) wr(4'h0, 16'h0056);
      8: sync_p <= on;
      default: step <= on ? 6'h03 : 6'h00;
    endcase
    if (k == 6 || k == 8) begin
      @(posedge clk_in);
      done_p <= 1'b0;
      sync_p <= 1'b0;
    end
  endtask : set_cause
  // Host reads drive and finish bits before the cause and six cycles after it
  task automatic drive_case(input logic [15:0] c, input int k, input logic [15:0] ef,
    input logic [15:0] mn);
    wr(4'h0, c);
    idle(2);
    rd(4'h0, 16'h0001, 16'h0003);
    rd(4'h2, 16'h0000, 16'hffff);
    set_cause(k, 1'b1);
    idle(6);
    rd(4'h0, mn, 16'h0003);
    rd(4'h2, ef, 16'hffff);
    set_cause(k, 0);
    idle(3);
  endtask : drive_case
  task automatic give_verdict;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Long hang guard, well past the expected run
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin : main
    logic [7:0] d, o;
    logic [3:0][31:0] m;
    logic [8:0][31:0] w;
    logic [31:0] obj;
    logic [15:0] e;
    idle(20);
    rst_in <= 1'b0;
    idle(3);
    rd(4'h2, 16'h0000, 16'hffff);
    rd(4'h3, 16'h8000, 16'hffff);
    rd(4'h4, 16'h00ff, 16'hffff);
    rd(4'h6, 16'h0000, 16'hffff);
    rd(4'he, 16'h0000, 16'hffff);
    wr(4'h1, 16'h003e);
    wr(4'ha, 16'h1000);
    wr(4'hb, 16'h0000);
    wr(4'hc, 16'hf000);
    wr(4'hd, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      pins_in <= {1'b1, 9'($random(seed))};
      step <= 6'($random(seed));
      wr(4'h1, {5'h00, i[0], 10'h03e});
      idle(3);
      rd(4'h3, {pins_in.emg_n, step, pins_in[8:0]}, 16'hffff);
    end
    rd(4'h2, 16'h0000, 16'hffff);
    @(posedge clk_in);
    pins_in <= 10'h200;
    step <= 6'h00;
    wr(4'h1, 16'h003e);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      o = 8'($random(seed));
      wr(4'h8, {8'h00, d});
      wr(4'h9, {8'h00, o});
      @(posedge clk_in);
      gio_ext <= 8'($random(seed));
      upper_in <= 8'($random(seed));
      bus_wide <= i[0];
      idle(3);
      rd(4'h5, {bus_wide ? 8'h00 : upper_in, (d & o) | (~d & gio_ext)}, 16'hffff);
      check({gio_oe_out, gio_out}, {d, o}, 16'hffff);
    end
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) m[j] = $random(seed);
      obj = (i < 2) ? m[i + 2] : $random(seed);
      @(posedge clk_in);
      src.mpreg <= m;
      cmp_obj <= obj;
      idle(3);
      for (int j = 0; j < 4; j++) e[2 * j +: 2] = {obj == m[j], $signed(obj) >= $signed(m[j])};
      rd(4'h4, {8'h00, e[7:0]}, 16'hffff);
    end
    for (int j = 0; j < 9; j++) w[j] = $random(seed);
    @(posedge clk_in);
    src <= msr_sources_t'(w);
    for (int c = 0; c < 9; c++) begin
      wr(4'h0, 16'h0030 + 16'(c));
      idle(2);
      rd(4'h6, w[c][15:0], 16'hffff);
      rd(4'h7, w[c][31:16], 16'hffff);
    end
    rd(4'h7, w[8][31:16], 16'hffff);
    drive_case(16'h0050, 0, 16'h8020, 16'h0002);
    rd(4'h2, 16'h8020, 16'hffff);
    wr(4'h0, 16'h0079);
    idle(2);
    rd(4'h2, 16'h0000, 16'hffff);
    drive_case(16'h0050, 1, 16'h4010, 16'h0002);
    drive_case(16'h0050, 2, 16'h1004, 16'h0002);
    set_cause(2, 1'b1);
    idle(3);
    wr(4'h0, 16'h0079);
    wr(4'h0, 16'h0050);
    idle(2);
    rd(4'h0, 16'h0002, 16'h0003);
    rd(4'h2, 16'h0004, 16'hffff);
    set_cause(2, 0);
    idle(3);
    drive_case(16'h0051, 3, 16'h2008, 16'h0002);
    drive_case(16'h0050, 4, 16'h0001, 16'h0002);
    drive_case(16'h0051, 5, 16'h0002, 16'h0002);
    drive_case(16'h0050, 6, 16'h0000, 16'h0000);
    drive_case(16'h0050, 7, 16'h0000, 16'h0000);
    drive_case(16'h0050, 8, 16'h0100, 16'h0000);
    drive_case(16'h0050, 9, 16'h0040, 16'h0002);
    drive_case(16'h0050, 3, 16'h0000, 16'h0001);
    drive_case(16'h0050, 7, 16'h0000, 16'h0000);
    drive_case(16'h0051, 2, 16'h0000, 16'h0001);
    check(16'(drv_neg), 16'h0001, 16'h0001);
    drive_case(16'h0050, 7, 16'h0000, 16'h0000);
    idle(3);
    give_verdict();
  end
endmodule : testbench
